/* File: bench/dsp_ctl_model.sv */
// Purpose: controller model for the burst sram pins
// Assumes: commands and beat0 launch on falling mclk, beat1 on rising
// Notes:   launching mid-cycle keeps clear of the sampling edges
`timescale 1ns/1ns
module dsp_ctl_model
  import dsp_pkg::*;
(
  // clocks
  input  wire logic             mclk,
  output logic                  out_clk,
  // command pins
  output logic                  load_strobe_n,
  output logic                  rd_wr_sel,
  output logic      [AW-1:0]    word_ptr,
  // write port
  output logic      [DW-1:0]    wdata,
  output logic      [LANES-1:0] byte_lane_enable_n
);
  localparam int CW = AW + 2 * DW + 2 * LANES + 1;
  localparam int BW = DW + LANES;
  logic [CW-1:0] q[$];
  logic [CW-1:0] c;
  logic [BW:0]   b1;

  task automatic put(input logic rw, input logic [AW-1:0] a,
                     input logic [DW-1:0] w0, w1,
                     input logic [LANES-1:0] e0, e1);
    q.push_back({rw, a, w0, e0, w1, e1});
  endtask

  initial begin
    {load_strobe_n, rd_wr_sel, word_ptr, wdata} = '1;
    byte_lane_enable_n = '1;
    b1 = '0;
    out_clk = 1'b0;
    forever #6 out_clk = ~out_clk;
  end

  always @(negedge mclk) begin
    if (q.size() != 0) begin
      c = q.pop_front();
      load_strobe_n <= 1'b0;
      {rd_wr_sel, word_ptr, wdata, byte_lane_enable_n} <= c[CW-1:BW];
      b1 <= {~c[CW-1], c[BW-1:0]};
    end else begin
      // released lines flip, except load_strobe_n which goes high and the byte enables which hold, so stale values never look valid
      load_strobe_n <= 1'b1;
      rd_wr_sel <= ~rd_wr_sel;
      word_ptr <= ~word_ptr;
      wdata <= ~wdata;
      b1 <= '0;
    end
  end

  always @(posedge mclk) begin
    if (b1[BW])
      {wdata, byte_lane_enable_n} <= b1[BW-1:0];
    else
      wdata <= ~wdata;
  end
endmodule

/* File: bench/dsp_sram_pins_tb.sv */
// Purpose: self checking bench for the burst sram pins
// Assumes: single clock mode except in the last scenario
// Notes:   a pin monitor keeps the expected array contents
`timescale 1ns/1ns
module dsp_sram_pins_tb
  import dsp_pkg::*;
;
  logic             mclk;
  logic             out_clk;
  logic             reset;
  logic             load_strobe_n;
  logic             rd_wr_sel;
  logic             one_clk_mode;
  logic [AW-1:0]    word_ptr;
  logic [DW-1:0]    wdata;
  logic [DW-1:0]    q_out;
  logic [LANES-1:0] byte_lane_enable_n;
  logic             q_oe_n;
  logic [DW-1:0]    m0 [int];
  logic [DW-1:0]    m1 [int];
  logic [DW-1:0]    x0, x1, e0, e1;
  logic             rd_pend, wr_pend, now_rd;
  int               wa, error_cnt, n_checks;

  dsp_sram_pins i_dsp_sram_pins (.mclk(mclk), .out_clk(out_clk),
    .reset(reset), .load_strobe_n(load_strobe_n), .rd_wr_sel(rd_wr_sel),
    .word_ptr(word_ptr), .one_clk_mode(one_clk_mode), .wdata(wdata),
    .byte_lane_enable_n(byte_lane_enable_n), .q_out(q_out),
    .q_oe_n(q_oe_n));
  dsp_ctl_model i_dsp_ctl_model (.mclk(mclk), .out_clk(out_clk),
    .load_strobe_n(load_strobe_n), .rd_wr_sel(rd_wr_sel),
    .word_ptr(word_ptr), .wdata(wdata),
    .byte_lane_enable_n(byte_lane_enable_n));

  task automatic chk(input string nm, input logic [DW-1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, d,
                                          input logic [LANES-1:0] be_n);
    merge = old;
    for (int i = 0; i < LANES; i++)
      if (!be_n[i]) merge[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
  endfunction

  always @(posedge mclk) begin
    now_rd = rd_pend;
    e0 = x0;
    e1 = x1;
    rd_pend = !reset && !load_strobe_n && rd_wr_sel && one_clk_mode;
    wr_pend = !reset && !load_strobe_n && !rd_wr_sel;
    if (wr_pend) begin
      wa = int'(word_ptr);
      m0[wa] = merge(m0[wa], wdata, byte_lane_enable_n);
    end
    if (rd_pend) begin
      x0 = m0[int'(word_ptr)];
      x1 = m1[int'(word_ptr)];
    end
    #5;
    if (one_clk_mode && !reset) begin
      chk("q_oe_n", DW'(!now_rd), DW'(q_oe_n));
      if (now_rd) begin
        chk("q_out beat0", e0, q_out);
        @(negedge mclk);
        #5;
        chk("q_out beat1", e1, q_out);
      end
    end
  end

  always @(negedge mclk)
    if (wr_pend) m1[wa] = merge(m1[wa], wdata, byte_lane_enable_n);

  task automatic drain();
    while (i_dsp_ctl_model.q.size() != 0) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask

  // back to back at both ends of the pointer range, read after write
  task automatic t_rw();
    i_dsp_ctl_model.put(1'b0, '1, {LANES{9'h1a5}}, {LANES{9'h05a}}, '0, '0);
    i_dsp_ctl_model.put(1'b1, '1, '0, '0, '1, '1);
    i_dsp_ctl_model.put(1'b0, '0, {LANES{9'h0f0}}, {LANES{9'h10f}}, '0, '0);
    i_dsp_ctl_model.put(1'b1, '0, '0, '0, '1, '1);
    i_dsp_ctl_model.put(1'b1, '1, '0, '0, '1, '1);
    drain();
  endtask

  // beat0 enables only lane i, beat1 holds only lane i off, then idle cycles and a read back
  task automatic t_lanes();
    i_dsp_ctl_model.put(1'b0, AW'(3), '0, '0, '0, '0);
    for (int i = 0; i < LANES; i++) begin
      i_dsp_ctl_model.put(1'b0, AW'(3), {LANES{9'(i + 1)}},
        {LANES{9'(i + 7)}}, ~(LANES'(1) << i), LANES'(1) << i);
      i_dsp_ctl_model.put(1'b1, AW'(3), '0, '0, '1, '1);
    end
    drain();
    i_dsp_ctl_model.put(1'b1, AW'(3), '0, '0, '1, '1);
    drain();
  endtask

  // read data launched by the output clock pair
  task automatic t_cmode();
    int n;
    n = 0;
    one_clk_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    i_dsp_ctl_model.put(1'b0, AW'(9), {LANES{9'h0c3}}, {LANES{9'h13c}}, '0,
      '0);
    i_dsp_ctl_model.put(1'b1, AW'(9), '0, '0, '1, '1);
    while (q_oe_n !== 1'b0 && n < 40) begin
      @(posedge out_clk);
      #1;
      n++;
    end
    chk("q_oe_n c", DW'(1'b0), DW'(q_oe_n));
    chk("q_out c beat0", {LANES{9'h0c3}}, q_out);
    @(negedge out_clk);
    #1;
    chk("q_out c beat1", {LANES{9'h13c}}, q_out);
    @(posedge out_clk);
    #1;
    chk("q_oe_n c end", DW'(1'b1), DW'(q_oe_n));
    drain();
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    {reset, one_clk_mode} = 2'h3;
    {rd_pend, wr_pend, error_cnt, n_checks} = '0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    t_rw();
    t_lanes();
    t_cmode();
    end_of_test();
  end

  // whole run is well under two hundred mclk cycles
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
endmodule

/* File: design/dsp_pkg.sv */
// Purpose: shared constants and types for the burst sram pin block
// Assumes: one part size chosen by WIDE_PART
// Notes:   lane width is fixed at nine bits per byte enable
package dsp_pkg;
  localparam bit WIDE_PART = 1'b0;
  localparam int DW        = WIDE_PART ? 36 : 18;
  localparam int AW        = WIDE_PART ? 18 : 19;
  localparam int LANE_W    = 9;
  localparam int LANES     = DW / LANE_W;
  localparam int BURST_LEN = 2;
  localparam int DEPTH     = 1 << AW;
  localparam logic [DW-1:0]    DATA_RST = '0;
  localparam logic [AW-1:0]    ADDR_RST = '0;
  localparam logic [LANES-1:0] BE_RST   = '1;

  typedef enum logic [1:0] {
    CMD_IDLE  = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h3
  } dsp_cmd_e;

  typedef struct packed {
    dsp_cmd_e         cmd;
    logic [AW-1:0]    addr;
    logic [DW-1:0]    d0;
    logic [LANES-1:0] be0_n;
    logic [1:0]       mode_sy;
    logic             rd_tgl;
    logic             k_oe_n;
  } dsp_state_s;

  typedef struct packed {
    logic [2:0]    tgl_sy;
    logic [DW-1:0] q0;
    logic [DW-1:0] q1;
    logic          oe_n;
  } dsp_link_s;
endpackage

/* File: design/dsp_sram_pins.sv */
// Purpose: pin level logic of a two word burst sram, separate data ports
// Assumes: commands, address and write data synchronous to mclk (K);
//          falling mclk edge stands for the rising edge of K complement;
//          out_clk is C, its falling edge stands for C complement
// Notes:   read data reaches the pins one K cycle after the load in single clock mode, later through the C link
//
// Operation
// - write data is sampled on the rising K edge and the rising K# edge.
// - every transaction moves exactly two words in one clock period.
// - byte enables are active low, sampled with their beat, gate writes.
// - enable n governs data bits 9n+8 down to 9n.
// - one shared word pointer is captured on the rising K edge.
// - the pointer selects a location in two arrays, one per beat.
// - the word pointer is ignored while its port is deselected.
// - read beats leave on C and C#, or on K and K# in single clock mode.
// - the read bus floats by itself whenever the read port is idle.
// - with load low the direction pin selects read high, write low.
// - the C pair together launches read data to cancel flight skew.
// - accesses start only on the rising K edge.
`timescale 1ns/1ns
module dsp_sram_pins
  import dsp_pkg::*;
(
  // clocks and reset
  input  wire logic             mclk,
  input  wire logic             out_clk,
  input  wire logic             reset,
  // command pins
  input  wire logic             load_strobe_n,
  input  wire logic             rd_wr_sel,
  input  wire logic [AW-1:0]    word_ptr,
  input  wire logic             one_clk_mode,
  // write port
  input  wire logic [DW-1:0]    wdata,
  input  wire logic [LANES-1:0] byte_lane_enable_n,
  // read port
  output logic      [DW-1:0]    q_out,
  output logic                  q_oe_n
);

  function automatic logic [DW-1:0] lane_mask(
    input logic [LANES-1:0] be_n
  );
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{~be_n[i]}};
    end
    return m;
  endfunction

  dsp_state_s st_ff;
  dsp_state_s nxt_st;
  dsp_link_s  ln_ff;
  dsp_link_s  nxt_ln;

  logic [DW-1:0]    arr0 [DEPTH];
  logic [DW-1:0]    arr1 [DEPTH];
  logic [DW-1:0]    rd0_ff;
  logic [DW-1:0]    rd1_ff;
  logic [DW-1:0]    d1_ff;
  logic [LANES-1:0] be1_n_ff;
  logic [DW-1:0]    kq_fall_ff;
  logic [DW-1:0]    cq_fall_ff;
  logic [DW-1:0]    m0;
  logic [DW-1:0]    m1;

  // command capture on the rising K edge
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.mode_sy = {st_ff.mode_sy[0], one_clk_mode};
    nxt_st.cmd     = CMD_IDLE;
    if (!load_strobe_n) begin
      nxt_st.cmd   = rd_wr_sel ? CMD_READ : CMD_WRITE;
      nxt_st.addr  = word_ptr;
    end
    if (!load_strobe_n && !rd_wr_sel) begin
      nxt_st.d0    = wdata;
      nxt_st.be0_n = byte_lane_enable_n;
    end
    nxt_st.k_oe_n  = (st_ff.cmd != CMD_READ);
    if (st_ff.cmd == CMD_READ) begin
      nxt_st.rd_tgl = ~st_ff.rd_tgl;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '{cmd: CMD_IDLE, addr: ADDR_RST, d0: DATA_RST,
                 be0_n: BE_RST, mode_sy: 2'h0, rd_tgl: 1'b0,
                 k_oe_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // second write beat on the K# edge
  always_ff @(negedge mclk or posedge reset) begin
    if (reset) begin
      d1_ff    <= DATA_RST;
      be1_n_ff <= BE_RST;
    end else begin
      d1_ff    <= wdata;
      be1_n_ff <= byte_lane_enable_n;
    end
  end

  assign m0 = lane_mask(st_ff.be0_n);
  assign m1 = lane_mask(be1_n_ff);

  // one location, two arrays: one word per beat
  always_ff @(posedge mclk) begin
    if (st_ff.cmd == CMD_WRITE) begin
      arr0[st_ff.addr] <= (arr0[st_ff.addr] & ~m0) | (st_ff.d0 & m0);
      arr1[st_ff.addr] <= (arr1[st_ff.addr] & ~m1) | (d1_ff & m1);
    end
  end

  // read words stay put until the next read, so the link side can copy
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd0_ff <= DATA_RST;
      rd1_ff <= DATA_RST;
    end else if (st_ff.cmd == CMD_READ) begin
      rd0_ff <= arr0[st_ff.addr];
      rd1_ff <= arr1[st_ff.addr];
    end
  end

  // single clock mode: second beat on K#
  always_ff @(negedge mclk or posedge reset) begin
    if (reset) begin
      kq_fall_ff <= DATA_RST;
    end else begin
      kq_fall_ff <= rd1_ff;
    end
  end

  // link side: toggle crossing, then one C period of data
  always_comb begin
    nxt_ln        = ln_ff;
    nxt_ln.tgl_sy = {ln_ff.tgl_sy[1:0], st_ff.rd_tgl};
    nxt_ln.oe_n   = 1'b1;
    if (ln_ff.tgl_sy[2] != ln_ff.tgl_sy[1]) begin
      nxt_ln.q0   = rd0_ff;
      nxt_ln.q1   = rd1_ff;
      nxt_ln.oe_n = 1'b0;
    end
  end

  always_ff @(posedge out_clk or posedge reset) begin
    if (reset) begin
      ln_ff <= '{tgl_sy: 3'h0, q0: DATA_RST, q1: DATA_RST, oe_n: 1'b1};
    end else begin
      ln_ff <= nxt_ln;
    end
  end

  always_ff @(negedge out_clk or posedge reset) begin
    if (reset) begin
      cq_fall_ff <= DATA_RST;
    end else begin
      cq_fall_ff <= ln_ff.q1;
    end
  end

  // ddr pins need a clock-steered mux of rise and fall flops
  always_comb begin
    if (st_ff.mode_sy[1]) begin
      q_out  = mclk ? rd0_ff : kq_fall_ff;
      q_oe_n = st_ff.k_oe_n;
    end else begin
      q_out  = out_clk ? ln_ff.q0 : cq_fall_ff;
      q_oe_n = ln_ff.oe_n;
    end
  end

  // checks on the K domain
  chk_idle_desel: assert property (@(posedge mclk)
    disable iff (reset)
    load_strobe_n |=> st_ff.cmd == CMD_IDLE)
    else $error("load high did not deselect");

  chk_dir_read: assert property (@(posedge mclk)
    disable iff (reset)
    (!load_strobe_n && rd_wr_sel) |=> st_ff.cmd == CMD_READ)
    else $error("read direction not loaded");

  chk_dir_write: assert property (@(posedge mclk)
    disable iff (reset)
    (!load_strobe_n && !rd_wr_sel) |=> st_ff.cmd == CMD_WRITE)
    else $error("write direction not loaded");

  chk_ptr_ignore: assert property (@(posedge mclk)
    disable iff (reset)
    load_strobe_n |=> $stable(st_ff.addr))
    else $error("pointer taken while deselected");

  chk_ptr_capture: assert property (@(posedge mclk)
    disable iff (reset)
    !load_strobe_n |=> st_ff.addr == $past(word_ptr))
    else $error("pointer not captured");

  chk_beat0_take: assert property (@(posedge mclk)
    disable iff (reset)
    (!load_strobe_n && !rd_wr_sel) |=> st_ff.d0 == $past(wdata))
    else $error("first write beat not taken");

  chk_lane0_take: assert property (@(posedge mclk)
    disable iff (reset)
    (!load_strobe_n && !rd_wr_sel)
    |=> st_ff.be0_n == $past(byte_lane_enable_n))
    else $error("first beat enables not taken");

  chk_data_ignore: assert property (@(posedge mclk)
    disable iff (reset)
    (load_strobe_n || rd_wr_sel) |=> $stable(st_ff.d0))
    else $error("write data taken without a write");

  chk_read_float: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd != CMD_READ |=> st_ff.k_oe_n)
    else $error("read bus driven while idle");

  chk_read_drive: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd == CMD_READ |=> !st_ff.k_oe_n)
    else $error("read bus not driven");

  chk_burst_one: assert property (@(posedge mclk)
    disable iff (reset)
    (st_ff.cmd == CMD_READ) ##1 (st_ff.cmd != CMD_READ)
    |-> !st_ff.k_oe_n ##1 st_ff.k_oe_n)
    else $error("read burst not one period");

  chk_read_word: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd == CMD_READ
    |=> rd1_ff == arr1[$past(st_ff.addr)])
    else $error("wrong read word");

  chk_read_word0: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd == CMD_READ |=> rd0_ff == arr0[$past(st_ff.addr)])
    else $error("wrong first read word");

  chk_read_hold: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd != CMD_READ |=> $stable(rd0_ff) && $stable(rd1_ff))
    else $error("read words moved without a read");

  chk_write_full: assert property (@(posedge mclk)
    disable iff (reset)
    (st_ff.cmd == CMD_WRITE && st_ff.be0_n == '0)
    |=> arr0[$past(st_ff.addr)] == $past(st_ff.d0))
    else $error("enabled bytes not written");

  chk_beat1_write: assert property (@(posedge mclk)
    disable iff (reset)
    (st_ff.cmd == CMD_WRITE && be1_n_ff == '0)
    |=> arr1[$past(st_ff.addr)] == $past(d1_ff))
    else $error("second beat not written");

  chk_tgl_flip: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd == CMD_READ |=> st_ff.rd_tgl != $past(st_ff.rd_tgl))
    else $error("read not signalled to link");

  chk_tgl_hold: assert property (@(posedge mclk)
    disable iff (reset)
    st_ff.cmd != CMD_READ |=> $stable(st_ff.rd_tgl))
    else $error("link signalled without a read");

  // checks on the falling edges
  chk_beat1_take: assert property (@(negedge mclk)
    disable iff (reset)
    d1_ff == $past(wdata))
    else $error("second write beat not taken");

  chk_lane1_take: assert property (@(negedge mclk)
    disable iff (reset)
    be1_n_ff == $past(byte_lane_enable_n))
    else $error("second beat enables not taken");

  chk_kfall_beat: assert property (@(negedge mclk)
    disable iff (reset)
    kq_fall_ff == $past(rd1_ff))
    else $error("second read beat not staged");

  chk_cfall_beat: assert property (@(negedge out_clk)
    disable iff (reset)
    cq_fall_ff == $past(ln_ff.q1))
    else $error("second link beat not staged");

  // checks on the link domain
  chk_link_launch: assert property (@(posedge out_clk)
    disable iff (reset)
    (ln_ff.tgl_sy[2] != ln_ff.tgl_sy[1])
    |=> !ln_ff.oe_n ##1 ln_ff.oe_n)
    else $error("link burst not one period");

  chk_link_q0: assert property (@(posedge out_clk)
    disable iff (reset)
    (ln_ff.tgl_sy[2] != ln_ff.tgl_sy[1]) |=> ln_ff.q0 == $past(rd0_ff))
    else $error("link first word not copied");

  chk_link_q1: assert property (@(posedge out_clk)
    disable iff (reset)
    (ln_ff.tgl_sy[2] != ln_ff.tgl_sy[1]) |=> ln_ff.q1 == $past(rd1_ff))
    else $error("link second word not copied");

  chk_link_idle: assert property (@(posedge out_clk)
    disable iff (reset)
    (ln_ff.tgl_sy[2] == ln_ff.tgl_sy[1]) |=> ln_ff.oe_n)
    else $error("link drives without a read");

  cov_read: cover property (@(posedge mclk) disable iff (reset)
    st_ff.cmd == CMD_READ ##1 !st_ff.k_oe_n);
  cov_write: cover property (@(posedge mclk) disable iff (reset)
    st_ff.cmd == CMD_WRITE && st_ff.be0_n != '0);
  cov_b2b: cover property (@(posedge mclk) disable iff (reset)
    st_ff.cmd == CMD_WRITE ##1 st_ff.cmd == CMD_READ);
  cov_link: cover property (@(posedge out_clk) disable iff (reset)
    !ln_ff.oe_n);
  cov_kmode: cover property (@(posedge mclk) disable iff (reset)
    st_ff.mode_sy[1] && !st_ff.k_oe_n);

endmodule
